//--- pkg/cmac_pkg.sv
// cmac_pkg: constants, types and helpers for the cpu memory access control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package cmac_pkg;

  localparam int unsigned CLK_MHZ  = 125;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NUM_GPR  = 15;
  localparam int unsigned FUSE_W   = 256;

  // clock enable divisors, longest period rounds down, never below one
  localparam logic [4:0] DIV_4M  = 5'(CLK_MHZ / 4);
  localparam logic [4:0] DIV_8M  = 5'(CLK_MHZ / 8);
  localparam logic [4:0] DIV_16M = 5'(CLK_MHZ / 16);
  localparam logic [4:0] DIV_32M = 5'(CLK_MHZ / 32);

  // address map
  localparam logic [31:0] ROM_BASE    = 32'h0000_0000;
  localparam logic [31:0] OTP_BASE    = 32'h0100_0000;
  localparam logic [31:0] PERIPH_BASE = 32'h0200_0000;
  localparam logic [31:0] RAM_BASE    = 32'h0400_0000;
  localparam int unsigned MEM_AW      = 17;   // 128 KB
  localparam int unsigned OTP_AW      = 5;    // 32 bytes
  localparam int unsigned PERIPH_AW   = 24;

  // access cycles counted from the request to the response
  localparam logic [1:0] ROM_ACC_CYC    = 2'h1;
  localparam logic [1:0] RAM_ACC_CYC    = 2'h1;
  localparam logic [1:0] OTP_ACC_CYC    = 2'h1;
  localparam logic [1:0] PERIPH_ACC_CYC = 2'h3;

  // exception vectors
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_BUS   = 32'h0000_0008;
  localparam logic [31:0] VEC_IRQ   = 32'h0000_0010;
  localparam logic [31:0] VEC_PRIV  = 32'h0000_0018;
  localparam logic [31:0] PC_STEP   = 32'h0000_0004;

  // status register layout
  localparam int unsigned SR_SUP   = 0;
  localparam int unsigned SR_IE    = 1;
  localparam logic [31:0] SR_RESET = 32'h0000_0001;

  // special register selectors
  localparam logic [3:0] SPR_SR  = 4'h0;
  localparam logic [3:0] SPR_EPC = 4'h1;
  localparam logic [3:0] SPR_ESR = 4'h2;

  // fuse layout
  localparam int unsigned FUSE_ID_LSB  = 0;
  localparam int unsigned FUSE_KEY_LSB = 64;
  localparam int unsigned FUSE_KEY_W   = 128;
  localparam int unsigned FUSE_ENC_BIT = 192;

  typedef enum logic [1:0] {SPD_4M = 2'h0, SPD_8M = 2'h1, SPD_16M = 2'h2, SPD_32M = 2'h3}
    cmac_speed_t;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} cmac_size_t;
  typedef enum logic [2:0] {RG_NONE = 3'h0, RG_ROM = 3'h1, RG_RAM = 3'h2, RG_OTP = 3'h3,
                            RG_PERIPH = 3'h4} cmac_region_t;
  typedef enum logic [1:0] {ST_RUN = 2'h0, ST_MEM = 2'h1, ST_DOZE = 2'h3} cmac_state_t;
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_SUB = 5'h01, OP_AND = 5'h02, OP_OR = 5'h03, OP_XOR = 5'h04,
    OP_SHL = 5'h05, OP_SHR = 5'h06, OP_SRA = 5'h07, OP_ROR = 5'h08, OP_SLT = 5'h09,
    OP_SLTU = 5'h0A, OP_MUL = 5'h0B, OP_LOAD = 5'h0C, OP_STORE = 5'h0D, OP_MFS = 5'h0E,
    OP_MTS = 5'h0F, OP_RFE = 5'h10, OP_DOZE = 5'h11
  } cmac_op_t;

  // narrow a value to the operand size, sign or zero extended
  function automatic logic [31:0] cmac_ext(input logic [31:0] v, input logic [1:0] sz,
                                           input logic sgn);
    logic [31:0] r;
    r = v;
    if (sz == SZ_BYTE) begin
      r = {{24{sgn & v[7]}}, v[7:0]};
    end else if (sz == SZ_HALF) begin
      r = {{16{sgn & v[15]}}, v[15:0]};
    end
    return r;
  endfunction : cmac_ext

endpackage : cmac_pkg

//--- hw/cmac_alu.sv
// cmac_alu: combinational arithmetic, logic, shift, compare and multiply unit
`timescale 1ns/100ps
module cmac_alu
  import cmac_pkg::*;
(
  input  wire logic [4:0]  op_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic [1:0]  size_i,
  input  wire logic        sgn_i,
  output logic      [31:0] res_o
);

  logic [31:0] a_x;
  logic [31:0] b_x;
  logic [63:0] prod;
  logic [4:0]  sh;
  logic [31:0] raw;

  //----------------------------------------------------------------------------
  // operand shaping
  //----------------------------------------------------------------------------
  // operand size
  assign a_x  = cmac_ext(a_i, size_i, sgn_i);
  assign b_x  = cmac_ext(b_i, size_i, sgn_i);
  assign sh   = b_i[4:0];
  assign prod = a_x * b_x;

  //----------------------------------------------------------------------------
  // operation select
  //----------------------------------------------------------------------------
  // alu operations
  always_comb begin
    case (cmac_op_t'(op_i))
      OP_ADD:  raw = a_x + b_x;
      OP_SUB:  raw = a_x - b_x;
      OP_AND:  raw = a_x & b_x;
      OP_OR:   raw = a_x | b_x;
      OP_XOR:  raw = a_x ^ b_x;
      OP_SHL:  raw = a_x << sh;
      OP_SHR:  raw = a_x >> sh;
      OP_SRA:  raw = $signed(a_x) >>> sh;
      OP_ROR:  raw = (a_x >> sh) | (a_x << (6'd32 - {1'b0, sh}));
      OP_SLT:  raw = {31'h0, $signed(a_x) < $signed(b_x)};
      OP_SLTU: raw = {31'h0, a_x < b_x};
      OP_MUL:  raw = prod[31:0];
      default: raw = a_x;
    endcase
  end

  // result is cut back to the operand size so byte maths wraps like memory
  assign res_o = cmac_ext(raw, size_i, sgn_i);

endmodule : cmac_alu

//--- hw/cmac_top.sv
// cmac_top: register file, sequencing, privilege, exceptions, doze, address map
`timescale 1ns/100ps
module cmac_top
  import cmac_pkg::*;
(
  input  wire logic                REF_CLK_I,
  input  wire logic                RST_I,
  input  wire logic [1:0]          SPEED_SEL_I,
  input  wire logic                OP_VALID_I,
  input  wire logic [4:0]          OP_CODE_I,
  input  wire logic [3:0]          OP_RD_I,
  input  wire logic [3:0]          OP_RA_I,
  input  wire logic [3:0]          OP_RB_I,
  input  wire logic [31:0]         OP_IMM_I,
  input  wire logic                OP_USE_IMM_I,
  input  wire logic [1:0]          OP_SIZE_I,
  input  wire logic                OP_SIGNED_I,
  output logic                     OP_READY_O,
  input  wire logic                IRQ_I,
  output logic                     CPU_CE_O,
  output logic [31:0]              PC_O,
  output logic                     SUPERVISOR_O,
  output logic                     DOZE_O,
  output logic                     MEM_REQ_O,
  output logic [2:0]               MEM_REGION_O,
  output logic [31:0]              MEM_ADDR_O,
  output logic                     MEM_WE_O,
  output logic [3:0]               MEM_BE_O,
  output logic [31:0]              MEM_WDATA_O,
  input  wire logic [31:0]         MEM_RDATA_I,
  input  wire logic [FUSE_W-1:0]   FUSE_I,
  input  wire logic                BOOT_DONE_I,
  input  wire logic                BOOT_MEM_ACCESS_I,
  input  wire logic [3:0]          SPI_PERIPH_SEL_I,
  output logic                     BOOT_MEMORY_SELECT_O,
  output logic [3:0]               SPI_PERIPH_SEL_O,
  output logic                     BOOT_DECRYPT_O,
  output logic [FUSE_KEY_W-1:0]    BOOT_KEY_O,
  input  wire logic                RAM_RETAIN_REQ_I,
  output logic                     RAM_RETAIN_O
);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  logic [31:0]  gpr_q [NUM_GPR];
  cmac_state_t  st_q;
  logic [31:0]  pc_q, sr_q, epc_q, esr_q;
  logic [4:0]   div_q;
  logic [1:0]   wait_q, acc_q;
  logic [3:0]   ld_rd_q;
  logic [1:0]   ld_size_q, ld_lane_q;
  logic         ld_sgn_q, booting_q;
  logic [31:0]  otp_q;

  //----------------------------------------------------------------------------
  // clock enable divider
  //----------------------------------------------------------------------------
  logic [4:0] div_max;
  logic       ce;
  assign div_max = (SPEED_SEL_I == SPD_4M)  ? DIV_4M  :
                   (SPEED_SEL_I == SPD_8M)  ? DIV_8M  :
                   (SPEED_SEL_I == SPD_16M) ? DIV_16M : DIV_32M;
  assign ce      = (div_q == 5'h00);

  // a new rate takes effect at the next tick, so no short cycle appears
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || ce) begin
      div_q <= RST_I ? 5'h00 : 5'(div_max - 5'h01);
    end else begin
      div_q <= div_q - 5'h01;
    end
  end

  //----------------------------------------------------------------------------
  // decode
  //----------------------------------------------------------------------------
  cmac_op_t     op;
  cmac_region_t region;
  logic [31:0]  ra_val, rb_val, rd_val, opb, addr, alu_res, exc_vec, spr_val;
  logic         sup, irq_take, issue, is_mem, is_store, spr_op, priv_fault;
  logic         bus_fault, exc_take, mem_go, done, alu_op;

  assign op      = cmac_op_t'(OP_CODE_I);
  assign sup     = sr_q[SR_SUP];
  // index 15 has no register and reads zero
  assign ra_val  = (OP_RA_I < 4'(NUM_GPR)) ? gpr_q[OP_RA_I] : 32'h0000_0000;
  assign rb_val  = (OP_RB_I < 4'(NUM_GPR)) ? gpr_q[OP_RB_I] : 32'h0000_0000;
  assign rd_val  = (OP_RD_I < 4'(NUM_GPR)) ? gpr_q[OP_RD_I] : 32'h0000_0000;
  assign opb     = OP_USE_IMM_I ? OP_IMM_I : rb_val;
  assign addr    = ra_val + OP_IMM_I;

  assign region  = (addr[31:MEM_AW] == RAM_BASE[31:MEM_AW])          ? RG_RAM    :
                   (addr[31:MEM_AW] == ROM_BASE[31:MEM_AW])          ? RG_ROM    :
                   (addr[31:OTP_AW] == OTP_BASE[31:OTP_AW])          ? RG_OTP    :
                   (addr[31:PERIPH_AW] == PERIPH_BASE[31:PERIPH_AW]) ? RG_PERIPH : RG_NONE;

  assign is_mem   = (op == OP_LOAD) || (op == OP_STORE);
  assign is_store = (op == OP_STORE);
  assign spr_op   = (op == OP_MFS) || (op == OP_MTS) || (op == OP_RFE);
  assign alu_op   = (OP_CODE_I <= 5'(OP_MUL));

  // any interrupt wakes a dozing cpu
  assign irq_take   = ce && IRQ_I && (((st_q == ST_RUN) && sr_q[SR_IE]) || (st_q == ST_DOZE));
  assign issue      = ce && (st_q == ST_RUN) && OP_VALID_I && !irq_take;
  // user mode may not touch special registers
  assign priv_fault = issue && spr_op && !sup;
  // unpopulated, or a write into a read-only area
  assign bus_fault  = issue && is_mem &&
                      ((region == RG_NONE) || (is_store && (region != RG_RAM) &&
                                               (region != RG_PERIPH)));
  assign exc_take   = irq_take || priv_fault || bus_fault;
  assign exc_vec    = irq_take ? VEC_IRQ : (bus_fault ? VEC_BUS : VEC_PRIV);
  assign mem_go     = issue && is_mem && !bus_fault;
  assign done       = ce && (st_q == ST_MEM) && (wait_q == 2'h0);
  // nothing new is taken while an access is outstanding
  assign OP_READY_O = ce && (st_q == ST_RUN) && !irq_take;

  assign spr_val = (OP_RB_I == SPR_SR)  ? sr_q  :
                   (OP_RB_I == SPR_EPC) ? epc_q :
                   (OP_RB_I == SPR_ESR) ? esr_q : 32'h0000_0000;

  cmac_alu u_cmac_alu (
    .op_i   (OP_CODE_I),
    .a_i    (ra_val),
    .b_i    (opb),
    .size_i (OP_SIZE_I),
    .sgn_i  (OP_SIGNED_I),
    .res_o  (alu_res)
  );

  //----------------------------------------------------------------------------
  // register file write port
  //----------------------------------------------------------------------------
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [31:0] wr_data, ld_word, ld_raw;

  assign ld_raw  = (MEM_REGION_O == RG_OTP) ? otp_q : MEM_RDATA_I;
  assign ld_word = cmac_ext(ld_raw >> {ld_lane_q, 3'b000}, ld_size_q, ld_sgn_q);
  // register ops write at issue, loads when the access completes, one cpu tick later or three for a peripheral
  assign wr_en   = done ? !MEM_WE_O :
                   (issue && !exc_take && (alu_op || (op == OP_MFS)));
  assign wr_idx  = done ? ld_rd_q : OP_RD_I;
  assign wr_data = done ? ld_word : ((op == OP_MFS) ? spr_val : alu_res);

  for (genvar g = 0; g < NUM_GPR; g++) begin : g_gpr
    always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
        gpr_q[g] <= 32'h0000_0000;
      end else if (wr_en && (wr_idx == 4'(g))) begin
        gpr_q[g] <= wr_data;
      end
    end
  end

  //----------------------------------------------------------------------------
  // sequencer, status and exception registers
  //----------------------------------------------------------------------------
  logic [1:0] acc_cyc;
  assign acc_cyc = (region == RG_PERIPH) ? PERIPH_ACC_CYC :
                   (region == RG_OTP)    ? OTP_ACC_CYC    :
                   (region == RG_ROM)    ? ROM_ACC_CYC    : RAM_ACC_CYC;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      st_q   <= ST_RUN;
      pc_q   <= VEC_RESET;
      sr_q   <= SR_RESET;
      epc_q  <= 32'h0000_0000;
      esr_q  <= 32'h0000_0000;
      wait_q <= 2'h0;
    end else if (exc_take) begin
      epc_q <= pc_q;
      esr_q <= sr_q;
      pc_q  <= exc_vec;
      sr_q  <= (sr_q | (32'h1 << SR_SUP)) & ~(32'h1 << SR_IE);
      st_q  <= ST_RUN;
    end else if (issue) begin
      pc_q <= pc_q + PC_STEP;
      case (op)
        OP_MTS: begin
          if (OP_RB_I == SPR_SR) begin
            sr_q <= ra_val;
          end else if (OP_RB_I == SPR_EPC) begin
            epc_q <= ra_val;
          end else if (OP_RB_I == SPR_ESR) begin
            esr_q <= ra_val;
          end
        end
        OP_RFE: begin
          pc_q <= epc_q;
          sr_q <= esr_q;
        end
        OP_DOZE: st_q <= ST_DOZE;
        OP_LOAD, OP_STORE: begin
          st_q   <= ST_MEM;
          wait_q <= acc_cyc - 2'h1;
        end
        default: st_q <= ST_RUN;
      endcase
    end else if (ce && (st_q == ST_MEM)) begin
      if (wait_q == 2'h0) begin
        st_q <= ST_RUN;
      end else begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end

  //----------------------------------------------------------------------------
  // memory request registers
  //----------------------------------------------------------------------------
  logic [3:0]  be;
  logic [31:0] wdata;
  // byte enables and replicated store data
  assign be    = (OP_SIZE_I == SZ_BYTE) ? (4'h1 << addr[1:0]) :
                 (OP_SIZE_I == SZ_HALF) ? (addr[1] ? 4'hC : 4'h3) : 4'hF;
  assign wdata = (OP_SIZE_I == SZ_BYTE) ? {4{rd_val[7:0]}} :
                 (OP_SIZE_I == SZ_HALF) ? {2{rd_val[15:0]}} : rd_val;

  // request is a one-clock pulse, address and data stay until the next access
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      MEM_REQ_O    <= 1'b0;
      MEM_REGION_O <= RG_NONE;
      MEM_ADDR_O   <= 32'h0000_0000;
      MEM_WE_O     <= 1'b0;
      MEM_BE_O     <= 4'h0;
      MEM_WDATA_O  <= 32'h0000_0000;
      ld_rd_q      <= 4'h0;
      ld_size_q    <= SZ_WORD;
      ld_lane_q    <= 2'h0;
      ld_sgn_q     <= 1'b0;
      otp_q        <= 32'h0000_0000;
    end else begin
      MEM_REQ_O <= mem_go && (region != RG_OTP);
      if (mem_go) begin
        MEM_REGION_O <= region;
        MEM_ADDR_O   <= {addr[31:2], 2'b00};
        MEM_WE_O     <= is_store;
        MEM_BE_O     <= be;
        MEM_WDATA_O  <= wdata;
        ld_rd_q      <= OP_RD_I;
        ld_size_q    <= OP_SIZE_I;
        ld_lane_q    <= addr[1:0];
        ld_sgn_q     <= OP_SIGNED_I;
        // fuse array read as eight words
        otp_q        <= FUSE_I[{addr[4:2], 5'b00000} +: 32];
      end
    end
  end

  //----------------------------------------------------------------------------
  // boot memory, decryption key and retention
  //----------------------------------------------------------------------------
  logic enc_fuse;
  assign enc_fuse = FUSE_I[FUSE_ENC_BIT];

  // the key pins are only driven while booting, but OTP loads can still read the key fuse words
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      booting_q            <= 1'b1;
      BOOT_MEMORY_SELECT_O <= 1'b0;
      SPI_PERIPH_SEL_O     <= 4'h0;
      BOOT_DECRYPT_O       <= 1'b0;
      BOOT_KEY_O           <= '0;
      RAM_RETAIN_O         <= 1'b0;
    end else begin
      booting_q            <= booting_q && !BOOT_DONE_I;
      // select goes high for boot memory accesses only
      BOOT_MEMORY_SELECT_O <= BOOT_MEM_ACCESS_I;
      SPI_PERIPH_SEL_O     <= SPI_PERIPH_SEL_I;
      BOOT_DECRYPT_O       <= booting_q && !BOOT_DONE_I && enc_fuse;
      BOOT_KEY_O           <= (booting_q && !BOOT_DONE_I && enc_fuse) ?
                              FUSE_I[FUSE_KEY_LSB +: FUSE_KEY_W] : '0;
      RAM_RETAIN_O         <= RAM_RETAIN_REQ_I;
    end
  end

  assign CPU_CE_O     = ce;
  assign PC_O         = pc_q;
  assign SUPERVISOR_O = sr_q[SR_SUP];
  assign DOZE_O       = (st_q == ST_DOZE);

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  // helper: cpu ticks since the request
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || mem_go) begin
      acc_q <= 2'h0;
    end else if (ce && (st_q == ST_MEM)) begin
      acc_q <= acc_q + 2'h1;
    end
  end

  a_exc_save: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    exc_take |=> (epc_q == $past(pc_q)) && (esr_q == $past(sr_q)))
    else $error("state not saved on exception");
  a_exc_vector: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    exc_take |=> (pc_q == $past(exc_vec)) && (st_q == ST_RUN))
    else $error("vector not loaded");
  a_irq_super: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    irq_take |=> SUPERVISOR_O && !sr_q[SR_IE])
    else $error("interrupt did not enter supervisor");
  a_user_spr: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (issue && spr_op && !sup) |=> (pc_q == VEC_PRIV) && SUPERVISOR_O && (esr_q == $past(sr_q)))
    else $error("user touched special register");
  a_bus_error: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (issue && is_mem && (region == RG_NONE) && !irq_take) |=> (pc_q == VEC_BUS) && !MEM_REQ_O)
    else $error("no bus error on unpopulated address");
  a_periph_cyc: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (done && (MEM_REGION_O == RG_PERIPH)) |-> (acc_q == PERIPH_ACC_CYC - 2'h1))
    else $error("peripheral access length wrong");
  a_mem_stall: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ((st_q == ST_MEM) && ($past(st_q) == ST_MEM)) |-> !OP_READY_O && !MEM_REQ_O)
    else $error("new access during outstanding access");
  a_ram_one: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (mem_go && (region == RG_RAM)) |=> (st_q == ST_MEM) && (wait_q == 2'h0))
    else $error("ram access not single cycle");
  a_doze_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ((st_q == ST_DOZE) && !IRQ_I) |=> $stable(pc_q) && !OP_READY_O)
    else $error("execution during doze");
  a_key_hidden: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !booting_q |=> (BOOT_KEY_O == '0) && !BOOT_DECRYPT_O)
    else $error("key visible after boot");

endmodule : cmac_top

//--- sim/cmac_mem_model.sv
// cmac_mem_model: behavioural word memory on the block's access port
`timescale 1ns/100ps
module cmac_mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem_q [0:63];
  // only enabled lanes change, so a narrow store cannot clobber neighbours
  always_ff @(posedge clk_i) begin
    if (req_i && we_i) begin
      for (int i = 0; i < 4; i++) begin
        if (be_i[i]) mem_q[addr_i[7:2]][8*i +: 8] <= wdata_i[8*i +: 8];
      end
    end
  end
  // read word follows the held address, settled long before the response tick
  assign rdata_o = mem_q[addr_i[7:2]];
endmodule : cmac_mem_model

//--- sim/cmac_top_tb_top.sv
// cmac_top_tb_top: scenario testbench for the cpu memory access control block
`timescale 1ns/100ps
module cmac_top_tb_top;
  import cmac_pkg::*;
  logic clk = 0, rst = 1, v = 0, ui = 0, sg = 0, irq = 0, bd = 0, bma = 0, rr = 0;
  logic [1:0] spd = 2'h3, sz = 2'h2;
  logic [4:0] oc = 5'h00;
  logic [3:0] rd = 4'h0, ra = 4'h0, rb = 4'h0, sps = 4'h0;
  logic [31:0] imm = 32'h0;
  logic [255:0] fuse = '0;
  wire logic rdy, ce, sup, dz, req, we, bms, dec, ret;
  wire logic [31:0] pc, adr, wd, rdat;
  wire logic [2:0] rgn;
  wire logic [3:0] be, spo;
  wire logic [127:0] key;
  int n_errors = 0, checked = 0, lat, cyc = 0, n_req = 0;
  localparam logic [3:0] W = 4'hA;  // immediate, unsigned, word
  cmac_top u_cmac_top (.REF_CLK_I(clk), .RST_I(rst), .SPEED_SEL_I(spd), .OP_VALID_I(v),
    .OP_CODE_I(oc), .OP_RD_I(rd), .OP_RA_I(ra), .OP_RB_I(rb), .OP_IMM_I(imm),
    .OP_USE_IMM_I(ui), .OP_SIZE_I(sz), .OP_SIGNED_I(sg), .OP_READY_O(rdy), .IRQ_I(irq),
    .CPU_CE_O(ce), .PC_O(pc), .SUPERVISOR_O(sup), .DOZE_O(dz), .MEM_REQ_O(req),
    .MEM_REGION_O(rgn), .MEM_ADDR_O(adr), .MEM_WE_O(we), .MEM_BE_O(be), .MEM_WDATA_O(wd),
    .MEM_RDATA_I(rdat), .FUSE_I(fuse), .BOOT_DONE_I(bd), .BOOT_MEM_ACCESS_I(bma),
    .SPI_PERIPH_SEL_I(sps), .BOOT_MEMORY_SELECT_O(bms), .SPI_PERIPH_SEL_O(spo),
    .BOOT_DECRYPT_O(dec), .BOOT_KEY_O(key), .RAM_RETAIN_REQ_I(rr), .RAM_RETAIN_O(ret));
  cmac_mem_model u_cmac_mem_model (.clk_i(clk), .req_i(req), .we_i(we), .be_i(be),
    .addr_i(adr), .wdata_i(wd), .rdata_o(rdat));
  //----------------------------------------------------------------------------
  // clock, hang guard and helpers
  //----------------------------------------------------------------------------
  always #4 clk = ~clk;
  // a hung handshake ends the run as a failure instead of spinning forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // request pulses are counted, since each stands for one clock only
    if (req === 1'b1) n_req <= n_req + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [127:0] e, input logic [127:0] s);
    checked++;
    if (e !== s) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // offer one op until taken, then count negedges to the next ready (doze caps at 100)
  task op(input logic [4:0] c, input logic [3:0] d, a, b, input logic [31:0] i,
          input logic [3:0] m);
    @(posedge clk);
    {oc, rd, ra, rb, imm, ui, sg, sz} <= {c, d, a, b, i, m};
    v <= 1;
    lat = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && lat < 100) begin @(negedge clk); lat++; end
    @(posedge clk);
    v <= 0;
    lat = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && lat < 100) begin @(negedge clk); lat++; end
  endtask : op
  task irq_pulse;
    @(posedge clk) irq <= 1;
    repeat (8) @(posedge clk);
    irq <= 0;
    @(negedge clk);
  endtask : irq_pulse
  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task t_reset;
    @(negedge clk);
    chk("pc", VEC_RESET, pc);
    chk("sup", 1'b1, sup);
    chk("doze", 1'b0, dz);
    chk("req_idle", 1'b0, req);
  endtask : t_reset
  task t_speed;
    int p;
    int e[4];
    e = '{31, 15, 7, 3};
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) spd <= 2'(s);
      repeat (40) @(negedge clk);
      while (ce !== 1'b1) @(negedge clk);
      p = 0;
      do begin @(negedge clk); p++; end while (ce !== 1'b1 && p < 99);
      chk("ce_period", e[s], p);
    end
  endtask : t_speed
  task t_mem;
    int n0;
    op(OP_ADD, 4'h1, 4'hF, 4'h0, 32'h1234_56F8, W);
    chk("alu_lat", 2, lat);
    n0 = n_req;
    op(OP_STORE, 4'h1, 4'hF, 4'h0, RAM_BASE + 32'h10, W);
    chk("ram_lat", 5, lat);
    chk("req_count", n0 + 1, n_req);
    chk("addr", RAM_BASE + 32'h10, adr);
    chk("wdata", 32'h1234_56F8, wd);
    chk("region", RG_RAM, rgn);
    chk("we", 1'b1, we);
    op(OP_LOAD, 4'h2, 4'hF, 4'h0, RAM_BASE + 32'h10, 4'hC);
    chk("be_byte", 4'h1, be);
    op(OP_MUL, 4'h3, 4'h2, 4'h0, 32'h2, W);
    op(OP_STORE, 4'h3, 4'hF, 4'h0, PERIPH_BASE, W);
    chk("periph_lat", 11, lat);
    chk("mul_sext", 32'hFFFF_FFF0, wd);
    chk("be_word", 4'hF, be);
    op(OP_LOAD, 4'h4, 4'hF, 4'h0, ROM_BASE, W);
    chk("rom_lat", 5, lat);
  endtask : t_mem
  task t_err;
    int n0;
    n0 = n_req;
    op(OP_LOAD, 4'h5, 4'hF, 4'h0, 32'h0800_0000, W);
    chk("pc_unmapped", VEC_BUS, pc);
    op(OP_STORE, 4'h1, 4'hF, 4'h0, ROM_BASE, W);
    chk("pc_rom_store", VEC_BUS, pc);
    op(OP_STORE, 4'h1, 4'hF, 4'h0, OTP_BASE, W);
    chk("pc_otp_store", VEC_BUS, pc);
    chk("req_none", n0, n_req);
  endtask : t_err
  task t_irq;
    op(OP_ADD, 4'h6, 4'hF, 4'h0, 32'h3, W);
    op(OP_MTS, 4'h6, 4'h6, SPR_SR, 32'h0, W);
    irq_pulse();
    chk("pc_irq", VEC_IRQ, pc);
    chk("sup_irq", 1'b1, sup);
    op(OP_MFS, 4'h7, 4'h0, SPR_ESR, 32'h0, W);
    op(OP_STORE, 4'h7, 4'hF, 4'h0, RAM_BASE, W);
    chk("saved_sr", 32'h3, wd);
  endtask : t_irq
  task t_priv;
    op(OP_MTS, 4'hF, 4'hF, SPR_SR, 32'h0, W);
    chk("sup_drop", 1'b0, sup);
    op(OP_MFS, 4'h5, 4'h0, SPR_SR, 32'h0, W);
    chk("pc_priv", VEC_PRIV, pc);
    chk("sup_back", 1'b1, sup);
  endtask : t_priv
  task t_doze;
    op(OP_DOZE, 4'h0, 4'h0, 4'h0, 32'h0, W);
    chk("doze_on", 1'b1, dz);
    irq_pulse();
    chk("doze_off", 1'b0, dz);
    chk("pc_wake", VEC_IRQ, pc);
  endtask : t_doze
  task t_pins;
    int n0;
    @(posedge clk);
    fuse <= {63'h0, 1'b1, {4{32'hA5C3_0F1E}}, 64'h0};
    {bma, sps, rr} <= {1'b1, 4'h2, 1'b1};
    repeat (3) @(negedge clk);
    chk("decrypt", 1'b1, dec);
    chk("key", {4{32'hA5C3_0F1E}}, key);
    chk("boot_sel", 1'b1, bms);
    chk("spi_sel", 4'h2, spo);
    chk("retain", 1'b1, ret);
    // fuse word six carries the encrypted-boot bit in its lowest bit
    n0 = n_req;
    op(OP_LOAD, 4'h8, 4'hF, 4'h0, OTP_BASE + 32'h18, W);
    chk("otp_no_req", n0, n_req);
    op(OP_STORE, 4'h8, 4'hF, 4'h0, RAM_BASE + 32'h4, W);
    chk("otp_word", 32'h0000_0001, wd);
    @(posedge clk) bd <= 1;
    repeat (3) @(negedge clk);
    chk("decrypt_end", 1'b0, dec);
    chk("key_end", 128'h0, key);
  endtask : t_pins
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_reset();
    t_speed();
    t_mem();
    t_err();
    t_irq();
    t_priv();
    t_doze();
    t_pins();
    summarize();
  end
endmodule : cmac_top_tb_top
